// [inc/ubm_pkg.sv]
package ubm_pkg;

  localparam int          EP_NUM     = 16;
  localparam int          SETUP_LEN  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte wide, 8-bit address
  // Endpoint block: address = {idx[3:0], field[1:0]}; idx 0-7 in, 8-15 out
  localparam logic [7:0]  ADDR_EP_TOP    = 8'h40;
  localparam logic [7:0]  ADDR_STATUS    = 8'h40;
  localparam logic [7:0]  ADDR_SETUP_CLR = 8'h41;
  localparam logic [7:0]  ADDR_SETUP_BUF = 8'h48;
  localparam logic [7:0]  ADDR_SETUP_END = 8'h4F;

  localparam logic [1:0]  FLD_CFG    = 2'h0;
  localparam logic [1:0]  FLD_CNT_X  = 2'h1;
  localparam logic [1:0]  FLD_CNT_Y  = 2'h2;

  // Configuration byte fields
  localparam int          CFG_EN_BIT    = 7;
  localparam int          CFG_DBUF_BIT  = 6;
  localparam int          CFG_TOG_BIT   = 5;
  localparam int          CFG_HALT_BIT  = 3;
  localparam int          CFG_IEN_BIT   = 2;
  localparam int          CFG_HOLDY_BIT = 1;
  localparam int          CFG_HOLDX_BIT = 0;
  localparam logic [7:0]  CFG_RESET     = 8'h03;
  localparam logic [7:0]  CNT_RESET     = 8'h00;
  localparam int          STAT_SETUP_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    PID_SETUP = 2'h0,
    PID_OUT   = 2'h1,
    PID_IN    = 2'h2
  } ubm_pid_e;

  typedef enum logic [1:0] {
    CODE_ACK   = 2'h0,
    CODE_NAK   = 2'h1,
    CODE_STALL = 2'h2
  } ubm_hs_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RX   = 3'b010,
    ST_TXW  = 3'b100
  } ubm_st_e;

  typedef struct packed {
    logic       en;
    logic       dbuf;
    logic       tog;
    logic       halt;
    logic       ien;
    logic       hold_y;
    logic       hold_x;
    logic [7:0] cnt_x;
    logic [7:0] cnt_y;
  } ubm_epcfg_s;

  typedef struct packed {
    logic       vld;
    ubm_pid_e   pid;
    logic [2:0] ep;
  } ubm_tok_s;

  typedef struct packed {
    logic       start;
    logic       pid1;
    logic       buf_y;
    logic [7:0] cnt;
  } ubm_tx_s;

endpackage

// [core/ubm_ep_cfg.sv]
`timescale 1ns/1ps
module ubm_ep_cfg
  import ubm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wr_i,
  input  wire logic [1:0]  fld_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        done_i,
  input  wire logic        cnt_we_i,
  input  wire logic [7:0]  cnt_i,
  output ubm_epcfg_s       cfg_o,
  output logic      [7:0]  rdata_o
);

  ubm_epcfg_s cfg_q;
  ubm_epcfg_s cfg_d;
  logic       sel_y;

  // Double buffering picks Y only when toggle is 1
  assign sel_y = cfg_q.dbuf & cfg_q.tog;

  always_comb begin
    cfg_d = cfg_q;
    if (wr_i && fld_i == FLD_CFG) begin
      cfg_d.en     = wdata_i[CFG_EN_BIT];
      cfg_d.dbuf   = wdata_i[CFG_DBUF_BIT];
      cfg_d.tog    = wdata_i[CFG_TOG_BIT];
      cfg_d.halt   = wdata_i[CFG_HALT_BIT];
      cfg_d.ien    = wdata_i[CFG_IEN_BIT];
      cfg_d.hold_y = wdata_i[CFG_HOLDY_BIT];
      cfg_d.hold_x = wdata_i[CFG_HOLDX_BIT];
    end
    if (wr_i && fld_i == FLD_CNT_X) begin
      cfg_d.cnt_x = wdata_i;
    end
    if (wr_i && fld_i == FLD_CNT_Y) begin
      cfg_d.cnt_y = wdata_i;
    end
    // Completion applied last so it wins over a colliding write
    // toggle flip, hold set
    if (done_i) begin
      cfg_d.tog = ~cfg_q.tog;
      if (sel_y) begin
        cfg_d.hold_y = 1'b1;
      end else begin
        cfg_d.hold_x = 1'b1;
      end
      if (cnt_we_i && sel_y) begin
        cfg_d.cnt_y = cnt_i;
      end else if (cnt_we_i) begin
        cfg_d.cnt_x = cnt_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cfg_q <= {CFG_RESET[7:6], CFG_RESET[5], CFG_RESET[3:0], CNT_RESET,
                CNT_RESET};
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_o   = cfg_q;
  assign rdata_o = (fld_i == FLD_CFG)   ? {cfg_q.en, cfg_q.dbuf, cfg_q.tog,
                                           1'b0, cfg_q.halt, cfg_q.ien,
                                           cfg_q.hold_y, cfg_q.hold_x} :
                   (fld_i == FLD_CNT_X) ? cfg_q.cnt_x :
                   (fld_i == FLD_CNT_Y) ? cfg_q.cnt_y : 8'h00;

endmodule

// [core/ubm_top.sv]
`timescale 1ns/1ps
// How it works
// - Good setup: store, flag, ACK, event
// - Setup flag pending forces NAK on ep0
// - Clearing setup event clears pending flag
// - Acked in packet: flip toggle, hold, event
// - In token: hold gives NAK, halt STALL
// - No host handshake: resend same packet
// - Good status out: count, toggle, hold, ACK
// - Corrupted out packet gets no handshake
// - Endpoints one to seven usable as interrupt
// - Good out packet: store, toggle, hold, ACK
// - Out with hold NAK, with halt STALL
// - Out double buffer: toggle picks X or Y
// - In double buffer: toggle picks X or Y
module ubm_top
  import ubm_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  input  ubm_tok_s         TOK_I,
  input  wire logic        RX_BYTE_VLD_I,
  input  wire logic [7:0]  RX_BYTE_I,
  input  wire logic        PKT_END_I,
  input  wire logic        PKT_ERR_I,
  input  wire logic [7:0]  PKT_CNT_I,
  input  wire logic        HOST_ACK_I,
  input  wire logic        HOST_TMO_I,
  output logic             HS_VLD_O,
  output ubm_hs_e          HS_CODE_O,
  output ubm_tx_s          TX_O,
  output logic             RX_WR_EN_O,
  output logic             RX_BUF_Y_O,
  output logic             SETUP_PEND_O,
  output logic             SETUP_EVT_O,
  output logic      [15:0] EP_EVT_O
);

  ////////////////////////////////////////////////////////////////////////////
  ubm_st_e     state_q;
  logic [3:0]  ep_q;
  ubm_hs_e     resp_q;
  logic        acc_q;
  logic        setup_q;
  logic        pend_q;
  logic [2:0]  sptr_q;
  logic [7:0]  sbuf_q [SETUP_LEN];
  logic        hs_vld_q;
  ubm_hs_e     hs_code_q;
  ubm_tx_s     tx_q;
  logic        rx_wr_q;
  logic        rx_y_q;
  logic        sevt_q;
  logic [15:0] evt_q;
  logic [7:0]  rdata_q;

  ubm_epcfg_s  ep_cfg [EP_NUM];
  logic [7:0]  ep_rd  [EP_NUM];
  logic [15:0] done_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire logic       ep_space  = REG_ADDR_I < ADDR_EP_TOP;
  wire logic [3:0] reg_idx   = REG_ADDR_I[5:2];
  wire logic [1:0] reg_fld   = REG_ADDR_I[1:0];
  wire logic       setup_clr = REG_WR_I && REG_ADDR_I == ADDR_SETUP_CLR;
  wire logic       sbuf_hit  = REG_ADDR_I >= ADDR_SETUP_BUF &&
                               REG_ADDR_I <= ADDR_SETUP_END;
  wire logic [7:0] rd_mux;

  assign rd_mux = ep_space                  ? ep_rd[reg_idx] :
                  REG_ADDR_I == ADDR_STATUS ? {7'h00, pend_q} :
                  sbuf_hit                  ? sbuf_q[REG_ADDR_I[2:0]] :
                                              8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Token decode, all in one cycle against the endpoint bank
  wire logic       tok_in    = TOK_I.pid == PID_IN;
  wire logic [3:0] tok_idx   = {~tok_in, TOK_I.ep};
  wire ubm_epcfg_s tcfg      = ep_cfg[tok_idx];
  wire logic       tsel_y    = tcfg.dbuf & tcfg.tog;
  wire logic       thold     = tsel_y ? tcfg.hold_y : tcfg.hold_x;
  wire logic       tok_ep0   = TOK_I.ep == 3'h0;
  wire logic       tok_setup = TOK_I.vld && TOK_I.pid == PID_SETUP &&
                               tok_ep0;
  wire logic       tok_data  = TOK_I.vld && TOK_I.pid != PID_SETUP &&
                               tcfg.en;
  wire ubm_hs_e    tresp;
  wire ubm_epcfg_s cur_cfg   = ep_cfg[ep_q];
  wire logic       in_idle   = state_q == ST_IDLE;
  wire logic       in_rx     = state_q == ST_RX;
  wire logic       in_txw    = state_q == ST_TXW;
  wire logic       rx_good   = in_rx && PKT_END_I && !PKT_ERR_I;
  wire logic       done_any  = (in_txw && HOST_ACK_I) ||
                               (rx_good && acc_q && !setup_q);

  // pending setup overrides hold and halt on ep0
  // halt beats hold when both set
  assign tresp = (tok_ep0 && pend_q) ? CODE_NAK   :
                 tcfg.halt           ? CODE_STALL :
                 thold               ? CODE_NAK   : CODE_ACK;

  ////////////////////////////////////////////////////////////////////////////
  // every endpoint has the same bank
  genvar gi;
  generate
    for (gi = 0; gi < EP_NUM; gi++) begin : g_ep
      assign done_vec[gi] = done_any && ep_q == 4'(gi);
      ubm_ep_cfg u_ep (
        .clk_i    (SYS_CLK_I),
        .rst_b_i  (RST_B_I),
        .wr_i     (REG_WR_I && ep_space && reg_idx == 4'(gi)),
        .fld_i    (reg_fld),
        .wdata_i  (REG_WDATA_I),
        .done_i   (done_vec[gi]),
        .cnt_we_i (in_rx),
        .cnt_i    (PKT_CNT_I),
        .cfg_o    (ep_cfg[gi]),
        .rdata_o  (ep_rd[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      state_q   <= ST_IDLE;
      ep_q      <= 4'h0;
      resp_q    <= CODE_ACK;
      acc_q     <= 1'b0;
      setup_q   <= 1'b0;
      sptr_q    <= 3'h0;
      hs_vld_q  <= 1'b0;
      hs_code_q <= CODE_ACK;
      tx_q      <= '0;
      rx_wr_q   <= 1'b0;
      rx_y_q    <= 1'b0;
    end else begin
      hs_vld_q   <= 1'b0;
      tx_q.start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (tok_setup) begin
            state_q <= ST_RX;
            ep_q    <= 4'h8;
            setup_q <= 1'b1;
            acc_q   <= 1'b0;
            sptr_q  <= 3'h0;
          end else if (tok_data && !tok_in) begin
            state_q <= ST_RX;
            ep_q    <= tok_idx;
            setup_q <= 1'b0;
            resp_q  <= tresp;
            acc_q   <= tresp == CODE_ACK;
            rx_wr_q <= tresp == CODE_ACK;
            rx_y_q  <= tsel_y;
          end else if (tok_data && tresp == CODE_ACK) begin
            state_q <= ST_TXW;
            ep_q    <= tok_idx;
            tx_q    <= '{start: 1'b1, pid1: tcfg.tog, buf_y: tsel_y,
                         cnt: tsel_y ? tcfg.cnt_y : tcfg.cnt_x};
          end else if (tok_data) begin
            hs_vld_q  <= 1'b1;
            hs_code_q <= tresp;
          end
        end
        ST_RX: begin
          if (setup_q && RX_BYTE_VLD_I) begin
            sptr_q <= sptr_q + 3'h1;
          end
          if (PKT_END_I) begin
            state_q <= ST_IDLE;
            rx_wr_q <= 1'b0;
            hs_vld_q  <= !PKT_ERR_I;
            hs_code_q <= setup_q ? CODE_ACK : resp_q;
          end
        end
        ST_TXW: begin
          // timeout just returns, packet stays armed
          // no completion, toggle and hold kept
          if (HOST_ACK_I || HOST_TMO_I) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // setup bytes land in their own buffer
  always_ff @(posedge SYS_CLK_I) begin
    if (in_rx && setup_q && RX_BYTE_VLD_I) begin
      sbuf_q[sptr_q] <= RX_BYTE_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup flag, events and read port
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      pend_q  <= 1'b0;
      sevt_q  <= 1'b0;
      evt_q   <= 16'h0000;
      rdata_q <= 8'h00;
    end else begin
      // clear of the event drops pending; a new setup wins
      if (rx_good && setup_q) begin
        pend_q <= 1'b1;
      end else if (setup_clr) begin
        pend_q <= 1'b0;
      end
      sevt_q <= rx_good && setup_q;
      // endpoint event gated by its enable
      for (int i = 0; i < EP_NUM; i++) begin
        evt_q[i] <= done_vec[i] & ep_cfg[i].ien;
      end
      rdata_q <= REG_RD_I ? rd_mux : 8'h00;
    end
  end

  assign REG_RDATA_O  = rdata_q;
  assign HS_VLD_O     = hs_vld_q;
  assign HS_CODE_O    = hs_code_q;
  assign TX_O         = tx_q;
  assign RX_WR_EN_O   = rx_wr_q;
  assign RX_BUF_Y_O   = rx_y_q;
  assign SETUP_PEND_O = pend_q;
  assign SETUP_EVT_O  = sevt_q;
  assign EP_EVT_O     = evt_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  setup_ack_a: assert property (
    rx_good && setup_q |=> HS_VLD_O && HS_CODE_O == CODE_ACK &&
                           SETUP_PEND_O && SETUP_EVT_O)
    else $error("setup not acknowledged");

  setup_nak_a: assert property (
    in_idle && TOK_I.vld && tok_in && tok_ep0 && tcfg.en && pend_q
    |=> HS_VLD_O && HS_CODE_O == CODE_NAK && in_idle)
    else $error("pending setup did not force NAK");

  setup_clr_a: assert property (
    setup_clr && !(rx_good && setup_q) |=> !SETUP_PEND_O)
    else $error("setup clear ignored");

  in_done_a: assert property (
    in_txw && HOST_ACK_I |=> cur_cfg.tog != $past(cur_cfg.tog) &&
                             (cur_cfg.hold_x || cur_cfg.hold_y) &&
                             EP_EVT_O[ep_q] == cur_cfg.ien)
    else $error("acked in packet not retired");

  in_refuse_a: assert property (
    in_idle && tok_data && tok_in && tresp != CODE_ACK
    |=> HS_VLD_O && !TX_O.start && HS_CODE_O == $past(tresp))
    else $error("in refusal wrong");

  in_retry_a: assert property (
    in_txw && HOST_TMO_I && !HOST_ACK_I && !REG_WR_I
    |=> cur_cfg.tog == $past(cur_cfg.tog) && EP_EVT_O == 16'h0000)
    else $error("unacked in packet changed state");

  out_err_a: assert property (
    in_rx && PKT_END_I && PKT_ERR_I |=> !HS_VLD_O [*2])
    else $error("handshake after corrupt packet");

  out_ack_a: assert property (
    rx_good && acc_q && !setup_q
    |=> HS_CODE_O == CODE_ACK && HS_VLD_O &&
        cur_cfg.tog != $past(cur_cfg.tog))
    else $error("good out packet not accepted");

  out_stall_a: assert property (
    in_idle && tok_data && !tok_in && tcfg.halt && !pend_q
    |=> in_rx && !RX_WR_EN_O && resp_q == CODE_STALL)
    else $error("halted out endpoint not stalled");

  tx_sel_a: assert property (
    in_idle && tok_data && tok_in && tresp == CODE_ACK
    |=> TX_O.start && TX_O.buf_y == $past(tsel_y) &&
        TX_O.pid1 == $past(tcfg.tog))
    else $error("wrong in buffer chosen");

  setup_c: cover property (rx_good && setup_q);
  in_ack_c: cover property (in_txw && HOST_ACK_I);
  in_tmo_c: cover property (in_txw && HOST_TMO_I);
  out_ack_c: cover property (rx_good && acc_q && RX_BUF_Y_O);

endmodule

// [verification/ubm_host_model.sv]
`timescale 1ns/1ps
// Host and serial engine stand-in: tokens, data packets, host handshakes
module ubm_host_model
  import ubm_pkg::*;
(
  input  wire logic        clk_i,
  output ubm_tok_s         tok_o,
  output logic             rx_vld_o,
  output logic      [7:0]  rx_byte_o,
  output logic             pkt_end_o,
  output logic             pkt_err_o,
  output logic      [7:0]  pkt_cnt_o,
  output logic             ack_o,
  output logic             tmo_o
);
  logic [7:0] byte_q = 8'h00;
  logic [7:0] cnt_q  = 8'h00;
  logic [7:0] pat_q  = 8'h5A;

  // Idle data lines toggle, so a stale byte never reads as valid
  always @(posedge clk_i) pat_q <= ~pat_q;
  assign rx_byte_o = rx_vld_o ? byte_q : pat_q;
  assign pkt_cnt_o = pkt_end_o ? cnt_q : pat_q;

  initial begin
    tok_o = '0;
    rx_vld_o = 1'b0;
    pkt_end_o = 1'b0;
    pkt_err_o = 1'b0;
    ack_o = 1'b0;
    tmo_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tok(input ubm_pid_e p, input logic [2:0] e);
    @(posedge clk_i);
    tok_o <= {1'b1, p, e};
    @(posedge clk_i);
    tok_o.vld <= 1'b0;
  endtask

  // Bytes A0, A1.. back to back, then the end strobe with the count
  task automatic pkt(input int n, input logic err);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_vld_o <= 1'b1;
      byte_q <= 8'hA0 + 8'(i);
    end
    @(posedge clk_i);
    rx_vld_o <= 1'b0;
    pkt_end_o <= 1'b1;
    pkt_err_o <= err;
    cnt_q <= 8'(n);
    @(posedge clk_i);
    pkt_end_o <= 1'b0;
    pkt_err_o <= 1'b0;
  endtask

  // Host answer after our data: ACK or silence, after dly idle cycles
  task automatic reply(input logic ok, input int dly);
    repeat (dly) @(posedge clk_i);
    @(posedge clk_i);
    ack_o <= ok;
    tmo_o <= ~ok;
    @(posedge clk_i);
    ack_o <= 1'b0;
    tmo_o <= 1'b0;
  endtask
endmodule

// [verification/ubm_top_tb.sv]
`timescale 1ns/1ps
module ubm_top_tb import ubm_pkg::*;;
  localparam logic [7:0]  EN   = 8'(1 << CFG_EN_BIT);
  localparam logic [7:0]  DB   = 8'(1 << CFG_DBUF_BIT);
  localparam logic [7:0]  TG   = 8'(1 << CFG_TOG_BIT);
  localparam logic [7:0]  HT   = 8'(1 << CFG_HALT_BIT);
  localparam logic [7:0]  IE   = 8'(1 << CFG_IEN_BIT);
  localparam logic [7:0]  HY   = 8'(1 << CFG_HOLDY_BIT);
  localparam logic [7:0]  HX   = 8'(1 << CFG_HOLDX_BIT);
  localparam logic [15:0] NONE = 16'hDEAD;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata, rxb, pcnt;
  ubm_tok_s    tok;
  logic        rxv, pend, perr, ack, tmo, hs_vld, rxwe, rxby, spend, sevt;
  ubm_hs_e     hs_code;
  ubm_tx_s     tx;
  logic [15:0] epevt, r, ev;
  logic [1:0]  s, w;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          i;

  ubm_top dut_u (.SYS_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .TOK_I(tok), .RX_BYTE_VLD_I(rxv), .RX_BYTE_I(rxb), .PKT_END_I(pend),
    .PKT_ERR_I(perr), .PKT_CNT_I(pcnt), .HOST_ACK_I(ack), .HOST_TMO_I(tmo),
    .HS_VLD_O(hs_vld), .HS_CODE_O(hs_code), .TX_O(tx), .RX_WR_EN_O(rxwe),
    .RX_BUF_Y_O(rxby), .SETUP_PEND_O(spend), .SETUP_EVT_O(sevt),
    .EP_EVT_O(epevt));
  ubm_host_model host_u (.clk_i(clk), .tok_o(tok), .rx_vld_o(rxv),
    .rx_byte_o(rxb), .pkt_end_o(pend), .pkt_err_o(perr), .pkt_cnt_o(pcnt),
    .ack_o(ack), .tmo_o(tmo));

  initial begin
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, well over ten times the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  function automatic logic [7:0] ea(input int idx, input logic [1:0] f);
    return {2'b00, 4'(idx), f};
  endfunction

  function automatic logic [15:0] hs(input ubm_hs_e c);
    return {8'hF0, 6'h00, c};
  endfunction

  function automatic logic [15:0] txe(input logic p, b, input logic [7:0] n);
    return {5'h00, 1'b1, p, b, n};
  endfunction

  // First answer within 20 cycles; NONE when the device stays silent
  task automatic resp();
    r = NONE;
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      if (hs_vld === 1'b1 || tx.start === 1'b1) begin
        r = (hs_vld === 1'b1) ? hs(hs_code) : {5'h00, tx};
        ev = epevt;
        s = {sevt, spend};
        break;
      end
    end
  endtask

  task automatic inx(input int e, input logic [15:0] exp);
    host_u.tok(PID_IN, 3'(e));
    resp();
    chk(r, exp);
  endtask

  task automatic outx(input int e, n, input logic err, input logic [15:0] x);
    host_u.tok(PID_OUT, 3'(e));
    @(negedge clk);
    w = {rxwe, rxby};
    host_u.pkt(n, err);
    resp();
    chk(r, x);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rchk(ea(3, FLD_CFG), CFG_RESET);
    rchk(ea(3, FLD_CNT_X), CNT_RESET);
    rchk(ADDR_STATUS, 8'h00);
    wr8(8'h80, 8'hFF);
    rchk(8'h80, 8'h00);
    // Setup while in ep0 is halted and not held
    wr8(ea(0, FLD_CFG), EN | HT);
    host_u.tok(PID_SETUP, 3'h0);
    host_u.pkt(SETUP_LEN, 1'b0);
    resp();
    chk(r, hs(CODE_ACK));
    chk({14'h0, s}, 16'h0003);
    for (i = 0; i < SETUP_LEN; i++) begin
      rchk(ADDR_SETUP_BUF + 8'(i), 8'hA0 + 8'(i));
    end
    inx(0, hs(CODE_NAK));
    // halt both ep0 halves before release
    wr8(ea(8, FLD_CFG), EN | HT);
    wr8(ADDR_SETUP_CLR, 8'h00);
    rchk(ADDR_STATUS, 8'h00);
    inx(0, hs(CODE_STALL));
    outx(0, 0, 1'b0, hs(CODE_STALL));
    // first data packet goes as DATA1
    wr8(ea(0, FLD_CNT_X), 8'h03);
    wr8(ea(0, FLD_CFG), EN | IE | TG);
    inx(0, txe(1'b1, 1'b0, 8'h03));
    host_u.reply(1'b1, 0);
    @(negedge clk);
    chk(epevt, 16'h0001);
    rchk(ea(0, FLD_CFG), EN | IE | HX);
    // status stage armed with toggle one
    wr8(ea(8, FLD_CFG), EN | IE | TG);
    outx(0, 0, 1'b1, NONE);
    outx(0, 0, 1'b0, hs(CODE_ACK));
    chk(ev, 16'h0100);
    rchk(ea(8, FLD_CFG), EN | IE | HX);
    wr8(ea(8, FLD_CFG), EN | IE);
    // in endpoint configured with holds set
    wr8(ea(1, FLD_CFG), EN | IE | HY | HX);
    inx(1, hs(CODE_NAK));
    wr8(ea(1, FLD_CNT_X), 8'h05);
    wr8(ea(1, FLD_CFG), EN | IE);
    inx(1, txe(1'b0, 1'b0, 8'h05));
    host_u.reply(1'b0, 0);
    rchk(ea(1, FLD_CFG), EN | IE);
    inx(1, txe(1'b0, 1'b0, 8'h05));
    host_u.reply(1'b1, 4);
    @(negedge clk);
    chk(epevt, 16'h0002);
    rchk(ea(1, FLD_CFG), EN | IE | TG | HX);
    wr8(ea(2, FLD_CNT_Y), 8'h07);
    wr8(ea(2, FLD_CFG), EN | DB | TG | HX);
    inx(2, txe(1'b1, 1'b1, 8'h07));
    host_u.reply(1'b1, 0);
    rchk(ea(2, FLD_CFG), EN | DB | HY | HX);
    // Out ep1 double buffered, two packets before service
    wr8(ea(9, FLD_CFG), EN | IE | DB);
    outx(1, 4, 1'b0, hs(CODE_ACK));
    chk({14'h0, w}, 16'h0002);
    chk(ev, 16'h0200);
    outx(1, 6, 1'b0, hs(CODE_ACK));
    chk({14'h0, w}, 16'h0003);
    outx(1, 2, 1'b0, hs(CODE_NAK));
    // software reads counts, holds and toggle
    rchk(ea(9, FLD_CNT_X), 8'h04);
    rchk(ea(9, FLD_CNT_Y), 8'h06);
    rchk(ea(9, FLD_CFG), EN | IE | DB | HY | HX);
    for (i = 1; i < 8; i++) begin
      wr8(ea(i, FLD_CFG), EN | HT);
      wr8(ea(8 + i, FLD_CFG), EN | HT);
      inx(i, hs(CODE_STALL));
      outx(i, 1, 1'b0, hs(CODE_STALL));
    end
    tally_and_finish();
  end
endmodule
